// [hs_i2c_map.svh]
// Constants of the high-speed two-wire write receiver.
// Assumes inclusion by bare name from the package and the design module.
`ifndef HS_I2C_MAP_SVH
`define HS_I2C_MAP_SVH

`define HSM_CODE_PREFIX   5'h01
`define DEV_ADDR_PREFIX   5'h13
`define CTRL_ZERO_MASK    8'hC8
`define CTRL_KIND_BIT     0
`define CTRL_SEL_HI       2
`define CTRL_SEL_LO       1
`define CTRL_UPD_HI       5
`define CTRL_UPD_LO       4
`define PD_LOW_MASK       8'h3F
`define BIT_CNT_LAST      3'h7
`define STAGE_RESET       10'h000
`define FIFO_DEPTH        4
`define FIFO_WIDTH        13

`endif

// [hs_i2c_pkg.sv]
// Types shared by the two-wire write receiver.
// Assumes the constant header is on the include path.
`default_nettype none
`include "hs_i2c_map.svh"

package hs_i2c_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_CTRL  = 3'b010,
    ST_HIGH  = 3'b011,
    ST_LOW   = 3'b100,
    ST_PDLOW = 3'b101,
    ST_SKIP  = 3'b110
  } rx_state_t;

  typedef struct packed {
    logic [1:0] channel;
    logic [1:0] update_ctl;
    logic       data_kind_flag;
    logic [7:0] value;
  } write_word_t;

  typedef struct packed {
    logic [1:0] pd;
    logic [7:0] code;
  } staging_t;

endpackage

`default_nettype wire

// [hs_i2c_dac_write_receiver.sv]
// Receive side of a high-speed two-wire slave in a quad 8-bit converter.
// Assumes bus pins arrive asynchronously and are resampled on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "hs_i2c_map.svh"

module write_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (count_reg < (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module hs_i2c_dac_write_receiver (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_b_o,
  input  wire logic        strap_addr_bit1_i,
  input  wire logic        strap_addr_bit0_i,
  output logic             wr_valid_o,
  input  wire logic        wr_ready_i,
  output logic [1:0]       wr_channel_o,
  output logic [1:0]       wr_update_ctl_o,
  output logic             wr_data_kind_flag_o,
  output logic [7:0]       wr_value_o,
  output logic [39:0]      channel_staging_o,
  output logic             busy_o
);
  // ****************************************************************
  // Pin synchronisers and bus events
  // ****************************************************************
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic [1:0] strap_sync0_reg;
  logic [1:0] strap_sync1_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      scl_sync_reg    <= 2'h3;
      sda_sync_reg    <= 2'h3;
      scl_prev_reg    <= 1'b1;
      sda_prev_reg    <= 1'b1;
      strap_sync0_reg <= 2'h0;
      strap_sync1_reg <= 2'h0;
    end else begin
      scl_sync_reg    <= {scl_sync_reg[0], scl_i};
      sda_sync_reg    <= {sda_sync_reg[0], sda_i};
      scl_prev_reg    <= scl_sync_reg[1];
      sda_prev_reg    <= sda_sync_reg[1];
      strap_sync0_reg <= {strap_sync0_reg[0], strap_addr_bit1_i};
      strap_sync1_reg <= {strap_sync1_reg[0], strap_addr_bit0_i};
    end
  end

  wire scl_s     = scl_sync_reg[1];
  wire sda_s     = sda_sync_reg[1];
  wire scl_rise  = scl_s && !scl_prev_reg;
  wire scl_fall  = !scl_s && scl_prev_reg;
  wire start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  wire stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // ****************************************************************
  // Byte shifter
  // ****************************************************************
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic       ack_phase_reg;
  logic       byte_done_reg;
  logic       ack_slot_reg;

  wire [7:0] byte_next = {shift_reg[6:0], sda_s};
  wire       last_bit  = (bit_cnt_reg == `BIT_CNT_LAST);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || start_det || stop_det) begin
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 3'h0;
      ack_phase_reg <= 1'b0;
      byte_done_reg <= 1'b0;
      ack_slot_reg  <= 1'b0;
    end else begin
      byte_done_reg <= 1'b0;
      if (scl_rise && !ack_phase_reg) begin
        // Bits arrive most significant first, so the code lands in order.
        shift_reg     <= byte_next;
        bit_cnt_reg   <= bit_cnt_reg + 3'h1;
        byte_done_reg <= last_bit;
      end else if (scl_fall && ack_phase_reg) begin
        // The eighth fall opens the acknowledge slot and the ninth closes it, so the
        // line only moves while the bus clock is low and never fakes a start.
        ack_slot_reg  <= !ack_slot_reg;
        ack_phase_reg <= !ack_slot_reg;
      end
      if (scl_rise && !ack_phase_reg && last_bit) begin
        ack_phase_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Write sequencer
  // ****************************************************************
  hs_i2c_pkg::rx_state_t state_reg;
  hs_i2c_pkg::rx_state_t state_next;
  logic [7:0]            ctrl_reg;
  logic                  ack_reg;
  logic                  push_reg;
  hs_i2c_pkg::write_word_t word_reg;
  hs_i2c_pkg::staging_t    stage_reg [4];
  logic                  fifo_ready;

  wire [1:0] sel_ch     = ctrl_reg[`CTRL_SEL_HI:`CTRL_SEL_LO];
  wire       addr_match = (shift_reg[7:3] == `DEV_ADDR_PREFIX) &&
                          (shift_reg[2] == strap_sync0_reg[1]) &&
                          (shift_reg[1] == strap_sync1_reg[1]) && !shift_reg[0];
  wire       ctrl_ok    = ((shift_reg & `CTRL_ZERO_MASK) == 8'h00);
  wire       pd_ok      = ((shift_reg & `PD_LOW_MASK) == 8'h00);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hs_i2c_pkg::ST_ADDR:  state_next = addr_match ? hs_i2c_pkg::ST_CTRL
                                                    : hs_i2c_pkg::ST_SKIP;
      hs_i2c_pkg::ST_CTRL: begin
        if (!ctrl_ok) begin
          state_next = hs_i2c_pkg::ST_SKIP;
        end else if (shift_reg[`CTRL_KIND_BIT]) begin
          state_next = hs_i2c_pkg::ST_PDLOW;
        end else begin
          state_next = hs_i2c_pkg::ST_HIGH;
        end
      end
      hs_i2c_pkg::ST_HIGH:  state_next = hs_i2c_pkg::ST_LOW;
      hs_i2c_pkg::ST_LOW:   state_next = ctrl_reg[`CTRL_KIND_BIT] ? hs_i2c_pkg::ST_SKIP
                                                                  : hs_i2c_pkg::ST_HIGH;
      hs_i2c_pkg::ST_PDLOW: state_next = hs_i2c_pkg::ST_LOW;
      default:              state_next = hs_i2c_pkg::ST_SKIP;
    endcase
  end

  wire ack_this = (state_reg == hs_i2c_pkg::ST_ADDR && addr_match) ||
                  (state_reg == hs_i2c_pkg::ST_CTRL && ctrl_ok) ||
                  (state_reg == hs_i2c_pkg::ST_HIGH) ||
                  (state_reg == hs_i2c_pkg::ST_LOW) ||
                  (state_reg == hs_i2c_pkg::ST_PDLOW && pd_ok);
  wire data_byte = (state_reg == hs_i2c_pkg::ST_HIGH) || (state_reg == hs_i2c_pkg::ST_PDLOW);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= hs_i2c_pkg::ST_IDLE;
      ctrl_reg  <= 8'h00;
      ack_reg   <= 1'b0;
      push_reg  <= 1'b0;
      word_reg  <= '0;
    end else begin
      push_reg <= push_reg && !fifo_ready;
      if (start_det) begin
        state_reg <= hs_i2c_pkg::ST_ADDR;
        ack_reg   <= 1'b0;
      end else if (stop_det) begin
        state_reg <= hs_i2c_pkg::ST_IDLE;
        ack_reg   <= 1'b0;
      end else if (byte_done_reg) begin
        state_reg <= state_next;
        // Hold the line low on a data byte only if the previous word has left word_reg, so no code is lost.
        ack_reg   <= ack_this && !(data_byte && push_reg);
        if (state_reg == hs_i2c_pkg::ST_CTRL) begin
          ctrl_reg <= shift_reg;
        end
        // A refused byte must leave no trace in staging or in the queue.
        if (data_byte && ack_this && !push_reg) begin
          word_reg.channel        <= sel_ch;
          word_reg.update_ctl     <= ctrl_reg[`CTRL_UPD_HI:`CTRL_UPD_LO];
          word_reg.data_kind_flag <= ctrl_reg[`CTRL_KIND_BIT];
          word_reg.value          <= shift_reg;
          push_reg                <= 1'b1;
        end
      end else if (scl_fall && !ack_phase_reg) begin
        ack_reg <= 1'b0;
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_stage
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
          stage_reg[ch] <= `STAGE_RESET;
        end else if (push_reg && fifo_ready && word_reg.channel == 2'(ch)) begin
          if (word_reg.data_kind_flag) begin
            stage_reg[ch].pd <= word_reg.value[7:6];
          end else begin
            stage_reg[ch].code <= word_reg.value;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Output queue and pins
  // ****************************************************************
  logic        q_valid;
  logic [12:0] q_data;

  write_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_ready),
    .in_data_i   (word_reg),
    .out_valid_o (q_valid),
    .out_ready_i (wr_ready_i && !wr_valid_o),
    .out_data_o  (q_data)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wr_valid_o          <= 1'b0;
      wr_channel_o        <= 2'h0;
      wr_update_ctl_o     <= 2'h0;
      wr_data_kind_flag_o <= 1'b0;
      wr_value_o          <= 8'h00;
      sda_o               <= 1'b1;
      sda_oe_b_o          <= 1'b1;
      channel_staging_o   <= 40'h0;
      busy_o              <= 1'b0;
    end else begin
      wr_valid_o <= q_valid && wr_ready_i && !wr_valid_o;
      if (q_valid && wr_ready_i && !wr_valid_o) begin
        {wr_channel_o, wr_update_ctl_o, wr_data_kind_flag_o, wr_value_o} <= q_data;
      end
      sda_o             <= 1'b0;
      sda_oe_b_o        <= !(ack_reg && ack_slot_reg);
      channel_staging_o <= {stage_reg[3], stage_reg[2], stage_reg[1], stage_reg[0]};
      busy_o            <= (state_reg != hs_i2c_pkg::ST_IDLE);
    end
  end
endmodule

`default_nettype wire

// [hs_i2c_dac_write_receiver_sva.sv]
// Port checker for the two-wire write receiver.
// Assumes it is bound onto every instance of the receiver.
`timescale 1ns/1ps
`default_nettype none
module hs_i2c_dac_write_receiver_sva (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_b_o,
  input wire logic        wr_valid_o,
  input wire logic        wr_ready_i,
  input wire logic [1:0]  wr_channel_o,
  input wire logic        wr_data_kind_flag_o,
  input wire logic [7:0]  wr_value_o,
  input wire logic [39:0] channel_staging_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_ack_on;
    $fell(sda_oe_b_o);
  endsequence
  sequence s_ack_held;
    !sda_oe_b_o [*8];
  endsequence
  AST_ACK_SPAN: assert property (s_ack_on |-> s_ack_held ##[1:40] sda_oe_b_o)
    else $error("ack length out of range");
  AST_ACK_LOW: assert property (!sda_oe_b_o |-> !sda_o)
    else $error("ack drives high");
  AST_ACK_BUSY: assert property (!sda_oe_b_o |-> busy_o)
    else $error("ack outside a transfer");
  AST_BUSY_START: assert property ($rose(busy_o) |-> scl_i && !sda_i)
    else $error("busy without start");
  AST_WORD_ONCE: assert property (wr_valid_o && wr_ready_i |=> !wr_valid_o)
    else $error("word repeated");
  AST_WORD_HOLD: assert property (!wr_valid_o |-> $stable(wr_value_o) &&
    $stable(wr_channel_o) && $stable(wr_data_kind_flag_o))
    else $error("word changed without a strobe");
  AST_ACK_SCL_LOW: assert property (($fell(sda_oe_b_o) || $rose(sda_oe_b_o)) |->
    !scl_i)
    else $error("ack edge while bus clock high");
  AST_PD_LOW: assert property (wr_valid_o && wr_data_kind_flag_o |->
    wr_value_o[5:0] == 6'h00)
    else $error("power-down word low bits set");
  AST_RST_STATE: assert property ($rose(rst_b_i) |-> sda_oe_b_o && !wr_valid_o &&
    !busy_o && channel_staging_o == 40'h0)
    else $error("reset state wrong");
endmodule
bind hs_i2c_dac_write_receiver hs_i2c_dac_write_receiver_sva i_sva (
  .ref_clk_i, .rst_b_i, .scl_i, .sda_i, .sda_o, .sda_oe_b_o, .wr_valid_o, .wr_ready_i,
  .wr_channel_o, .wr_data_kind_flag_o, .wr_value_o, .channel_staging_o, .busy_o
);
`default_nettype wire

// [i2c_master_model.sv]
// Behavioural two-wire bus master, 80 ns bit time.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  // The clock stands high between frames, as the pull-up leaves it.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start_cond();
    sda_o = 1'b1;
    #20;
    scl_o = 1'b1;
    #40;
    sda_o = 1'b0;
    #40;
    scl_o = 1'b0;
    #20;
  endtask
  task automatic stop_cond();
    sda_o = 1'b0;
    #20;
    scl_o = 1'b1;
    #40;
    sda_o = 1'b1;
    #40;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_o = (i > 0) ? b[i-1] : 1'b1;
      #20;
      scl_o = 1'b1;
      #20;
      ack = ~sda_i;
      #20;
      scl_o = 1'b0;
      #20;
    end
  endtask
endmodule
`default_nettype wire

// [hs_i2c_dac_write_receiver_tb_top.sv]
// Self-checking bench for the two-wire write receiver.
// Assumes the checker is bound in and the master model is compiled.
`timescale 1ns/1ps
`default_nettype none
module hs_i2c_dac_write_receiver_tb_top;
  logic                    ref_clk_i = 1'b0;
  logic                    rst_b_i = 1'b0;
  logic                    wr_ready = 1'b1;
  logic [1:0]              strap = 2'h0;
  logic                    scl, mst_sda, dev_sda, dev_oe_b, busy, wr_valid, kind, ack;
  logic [1:0]              ch, upd, acks;
  logic [7:0]              val, addr;
  logic [39:0]             stage;
  logic [1:0]              seen_ch, seen_upd;
  logic                    seen_kind;
  logic [7:0]              seen_val;
  wire hs_i2c_pkg::write_word_t seen = {seen_ch, seen_upd, seen_kind, seen_val};
  hs_i2c_pkg::write_word_t want, head;
  hs_i2c_pkg::write_word_t exp_q[$];
  int                      miscompares = 0;
  int                      total_checks = 0;
  wire logic               sda_line = mst_sda & (dev_oe_b | dev_sda);

  always #2.5 ref_clk_i = ~ref_clk_i;

  i2c_master_model i_mst (.scl_o(scl), .sda_o(mst_sda), .sda_i(sda_line));
  hs_i2c_dac_write_receiver i_dut (
    .ref_clk_i, .rst_b_i, .scl_i(scl), .sda_i(sda_line), .sda_o(dev_sda),
    .sda_oe_b_o(dev_oe_b), .strap_addr_bit1_i(strap[1]), .strap_addr_bit0_i(strap[0]),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_channel_o(seen_ch),
    .wr_update_ctl_o(seen_upd), .wr_data_kind_flag_o(seen_kind),
    .wr_value_o(seen_val), .channel_staging_o(stage), .busy_o(busy));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    i_mst.put_byte(b, ack);
    check(16'(ack), 16'(exp_ack));
  endtask

  task automatic open();
    i_mst.start_cond();
    xfer({5'h01, 3'($urandom)}, 1'b0);
    i_mst.start_cond();
    xfer(addr, 1'b1);
    xfer({2'h0, upd, 1'b0, ch, kind}, 1'b1);
  endtask

  task automatic pair(input logic [7:0] v);
    want = '{ch, upd, kind, v};
    exp_q.push_back(want);
    xfer(v, 1'b1);
    xfer(8'($urandom), 1'b1);
  endtask

  // Each word leaving the queue is matched against the oldest note.
  // The strobe is a single-cycle pulse, so it is looked at mid-cycle where it is settled.
  always @(negedge ref_clk_i) begin
    if (rst_b_i === 1'b1 && wr_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'h1, 16'h0);
      end else begin
        head = exp_q.pop_front();
        check(16'(seen), 16'(head));
      end
    end
  end

  initial begin
    #400000;
    miscompares++;
    complete_run();
  end

  initial begin
    void'($urandom(20));
    strap = 2'($urandom);
    addr = {5'h13, strap, 1'b0};
    repeat (20) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    for (int c = 0; c < 8; c++) begin
      {ch, kind} = 3'(c);
      upd = 2'($urandom);
      open();
      if (kind) begin
        val = {2'($urandom), 6'h00};
        pair(val);
        xfer(8'($urandom), 1'b0);
        check(16'(stage[ch*10+8 +: 2]), 16'(val[7:6]));
      end else begin
        repeat (3) pair(8'($urandom));
        check(16'(stage[ch*10 +: 10]), 16'(want.value));
      end
    end
    open();
    xfer(8'hC1, 1'b0);
    i_mst.start_cond();
    xfer(addr ^ 8'h02, 1'b0);
    xfer(8'($urandom), 1'b0);
    i_mst.start_cond();
    xfer(addr | 8'h01, 1'b0);
    i_mst.start_cond();
    xfer(addr, 1'b1);
    xfer({2'h0, upd, 1'b1, ch, 1'b0}, 1'b0);
    xfer(8'($urandom), 1'b0);
    i_mst.stop_cond();
    // The consumer stalls so the queue fills until bytes are refused.
    wr_ready = 1'b0;
    kind = 1'b0;
    open();
    repeat (4) pair(8'($urandom));
    repeat (2) begin
      val = 8'($urandom);
      i_mst.put_byte(val, ack);
      if (ack)
        exp_q.push_back('{ch, upd, kind, val});
      acks = {acks[0], ack};
      i_mst.put_byte(8'($urandom), ack);
    end
    check(16'(&acks), 16'h0);
    i_mst.stop_cond();
    wr_ready = 1'b1;
    for (int i = 0; i < 200 && exp_q.size() > 0; i++)
      @(negedge ref_clk_i);
    check(16'(exp_q.size()), 16'h0);
    complete_run();
  end
endmodule
`default_nettype wire
